// ===== src/sbt_defines.svh
// constants for the system bus tenure master
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH
`define SBT_BURST_BEATS 3'h4
`define SBT_LAST_BEAT 2'h3
`define SBT_TT_READ 5'h0A
`define SBT_TT_WRITE 5'h02
`define SBT_TSIZ_BURST 3'h2
`define SBT_RATIO_POS 28
`define SBT_RATIO_W 4
`define SBT_HID_RESET 32'h0000_0000
`define SBT_FIFO_DEPTH 4
`define SBT_DATA_W 64
`define SBT_ADDR_W 32
`define SBT_CNT_W 8
`endif

// ===== src/sbt_pkg.sv
// types for the system bus tenure master
package sbt_pkg;
  typedef enum logic [1:0] {
    SBT_A_IDLE = 2'b00,
    SBT_A_REQ = 2'b01,
    SBT_A_START = 2'b10,
    SBT_A_ACK = 2'b11
  } sbt_astate_t;

  typedef enum logic [1:0] {
    SBT_D_IDLE = 2'b00,
    SBT_D_LOAD = 2'b01,
    SBT_D_REQ = 2'b10,
    SBT_D_BEAT = 2'b11
  } sbt_dstate_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic burst;
    logic [3:0] size;
    logic wt;
    logic ci;
  } sbt_req_t;
endpackage

// ===== src/sbt_fifo_if.sv
// valid/ready carrier between the bus master and its read-data fifo
`timescale 1ns/1ns
interface sbt_fifo_if #(parameter int W = 64);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ===== src/sbt_fifo.sv
// small synchronous fifo, width and depth parameters
`timescale 1ns/1ns
module sbt_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // data ports
  sbt_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign port.in_ready = (count_r != (AW+1)'(DEPTH));
  assign port.out_valid = (count_r != '0);
  assign port.out_data = mem[rd_ptr_r];
  assign push = clk_en && port.in_valid && port.in_ready;
  assign pop = clk_en && port.out_valid && port.out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= port.in_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ===== src/sbt_bus_master.sv
// split-tenure system bus master with clock ratio report
`timescale 1ns/1ns
`include "sbt_defines.svh"

// Summary of operation
// - address bus carries no parity; none is driven or checked.
// - data path is 64 bits, eight bytes a beat, without parity.
// - single beat: its acknowledge also ends the data tenure.
// - burst: each acknowledge ends one beat; tenure ends after the last.
// - address acknowledge ends address phase; address retry forces reissue.
// - data retry makes the device repeat that beat instead of taking it.
// - request and win the address bus before driving an address.
// - request and win the data bus separately before moving data.
// - pulse the transfer begin strobe at the start of each transaction.
// - drive size, burst, write-through and cache-inhibit attributes with the address.
// - names ending _n are asserted low; transfer type code asserted high.
// - core clock is a multiple of the bus clock chosen by four config pins.
// - core clock has 50% duty and is phase aligned to the bus clock.
// - selected clock ratio is visible in an implementation config register.
// - a burst is four beats moving one 32-byte cache block.
// - a single beat completes in one bus clock, 8 to 64 bits wide.
module sbt_bus_master (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire sbt_pkg::sbt_req_t req_info,
  output logic done_pulse,
  // user write data
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [`SBT_DATA_W-1:0] wd_data,
  // user read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [`SBT_DATA_W-1:0] rd_data,
  // address tenure
  output logic addr_req_n,
  input wire logic addr_grant_n,
  output logic transfer_begin_n,
  output logic [`SBT_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [4:0] transfer_type_code,
  output logic [2:0] tsize_code,
  output logic burst_n,
  output logic write_thru_n,
  output logic cache_inh_n,
  input wire logic addr_ack_n,
  input wire logic address_retry_n,
  // data tenure
  output logic data_req_n,
  input wire logic data_grant_n,
  input wire logic [`SBT_DATA_W-1:0] data_in,
  output logic [`SBT_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic data_ack_n,
  input wire logic data_retry_n,
  // clocking
  input wire logic bus_clock_in,
  input wire logic [`SBT_RATIO_W-1:0] clk_ratio_cfg,
  output logic [31:0] implementation_config_reg_one,
  output logic clock_lock
);
  import sbt_pkg::*;

  sbt_astate_t astate_r;
  sbt_dstate_t dstate_r;
  sbt_req_t cur_r;
  logic [1:0] beat_r;
  logic data_pending_r;
  logic bclk_s1_r;
  logic bclk_s2_r;
  logic bclk_d_r;
  logic bus_tick;
  logic bus_fall;
  logic beat_ok;
  logic last_beat;
  logic cfg_taken_r;
  logic [`SBT_RATIO_W-1:0] ratio_r;
  logic [`SBT_CNT_W-1:0] hi_cnt_r;
  logic [`SBT_CNT_W-1:0] lo_cnt_r;
  logic [`SBT_CNT_W-1:0] hi_len_r;
  logic [`SBT_CNT_W-1:0] lo_len_r;
  logic [`SBT_CNT_W-1:0] prev_hi_r;

  sbt_fifo_if #(.W(`SBT_DATA_W)) rdq ();

  sbt_fifo #(.W(`SBT_DATA_W), .DEPTH(`SBT_FIFO_DEPTH)) u_rdq (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .port(rdq.fifo)
  );

  // bus clock sampled in the core domain; edges pace every bus action
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_d_r <= 1'b0;
    end else if (clk_en) begin
      bclk_s1_r <= bus_clock_in;
      bclk_s2_r <= bclk_s1_r;
      bclk_d_r <= bclk_s2_r;
    end
  end

  assign bus_tick = clk_en && bclk_s2_r && !bclk_d_r;
  assign bus_fall = clk_en && !bclk_s2_r && bclk_d_r;

  // ratio pins caught on the first enabled edge after reset release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_taken_r <= 1'b0;
      ratio_r <= '0;
    end else if (clk_en && !cfg_taken_r) begin
      cfg_taken_r <= 1'b1;
      ratio_r <= clk_ratio_cfg;
    end
  end

  // read-only view; no write path exists
  always_comb begin
    implementation_config_reg_one = `SBT_HID_RESET;
    implementation_config_reg_one[`SBT_RATIO_POS +: `SBT_RATIO_W] = ratio_r;
  end

  // high and low halves of the bus clock measured in core cycles
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
      hi_len_r <= '0;
      lo_len_r <= '0;
      prev_hi_r <= '0;
    end else if (clk_en) begin
      if (bus_tick) begin
        lo_len_r <= lo_cnt_r;
        lo_cnt_r <= '0;
        hi_cnt_r <= 8'h01;
      end else if (bus_fall) begin
        hi_len_r <= hi_cnt_r;
        prev_hi_r <= hi_len_r;
        hi_cnt_r <= '0;
        lo_cnt_r <= 8'h01;
      end else if (bclk_s2_r) begin
        if (hi_cnt_r != 8'hFF) begin
          hi_cnt_r <= hi_cnt_r + 1'b1;
        end
      end else if (lo_cnt_r != 8'hFF) begin
        lo_cnt_r <= lo_cnt_r + 1'b1;
      end
    end
  end

  // lock: equal halves, and the high half matching the previous high half, means aligned multiple
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clock_lock <= 1'b0;
    end else if (clk_en) begin
      clock_lock <= (hi_len_r != '0) && (hi_len_r == lo_len_r) && (hi_len_r == prev_hi_r);
    end
  end

  // one transaction in flight at a time keeps ordering trivial
  assign req_ready = clk_en && cfg_taken_r && (astate_r == SBT_A_IDLE) && (dstate_r == SBT_D_IDLE)
                     && !data_pending_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_r <= '0;
    end else if (req_valid && req_ready) begin
      cur_r <= req_info;
    end
  end

  // address tenure
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      astate_r <= SBT_A_IDLE;
    end else if (clk_en) begin
      unique case (astate_r)
        SBT_A_IDLE: begin
          if (req_valid && req_ready) begin
            astate_r <= SBT_A_REQ;
          end
        end
        SBT_A_REQ: begin
          if (bus_tick && !addr_grant_n) begin
            astate_r <= SBT_A_START;
          end
        end
        SBT_A_START: begin
          if (bus_tick) begin
            astate_r <= SBT_A_ACK;
          end
        end
        SBT_A_ACK: begin
          if (bus_tick && !address_retry_n) begin
            astate_r <= SBT_A_REQ;
          end else if (bus_tick && !addr_ack_n) begin
            astate_r <= SBT_A_IDLE;
          end
        end
      endcase
    end
  end

  // address pins registered, changed only on bus clock edges
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      addr_req_n <= 1'b1;
      transfer_begin_n <= 1'b1;
      addr_oe <= 1'b0;
      addr_out <= '0;
      transfer_type_code <= '0;
      tsize_code <= '0;
      burst_n <= 1'b1;
      write_thru_n <= 1'b1;
      cache_inh_n <= 1'b1;
    end else if (bus_tick) begin
      addr_req_n <= !((astate_r == SBT_A_REQ) && addr_grant_n);
      transfer_begin_n <= !((astate_r == SBT_A_REQ) && !addr_grant_n);
      if ((astate_r == SBT_A_REQ) && !addr_grant_n) begin
        addr_oe <= 1'b1;
        addr_out <= cur_r.addr;
        transfer_type_code <= cur_r.write ? `SBT_TT_WRITE : `SBT_TT_READ;
        tsize_code <= cur_r.burst ? `SBT_TSIZ_BURST : cur_r.size[2:0];
        burst_n <= !cur_r.burst;
        write_thru_n <= !cur_r.wt;
        cache_inh_n <= !cur_r.ci;
      end else if ((astate_r == SBT_A_ACK) && (!addr_ack_n || !address_retry_n)) begin
        addr_oe <= 1'b0;
      end
    end
  end

  // address acked without retry hands the transfer to the data tenure
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_pending_r <= 1'b0;
    end else if (clk_en) begin
      if (bus_tick && (astate_r == SBT_A_ACK) && address_retry_n && !addr_ack_n) begin
        data_pending_r <= 1'b1;
      end else if (dstate_r != SBT_D_IDLE) begin
        data_pending_r <= 1'b0;
      end
    end
  end

  assign beat_ok = bus_tick && (dstate_r == SBT_D_BEAT) && !data_ack_n && data_retry_n;
  assign last_beat = !cur_r.burst || (beat_r == `SBT_LAST_BEAT);
  assign wd_ready = clk_en && (dstate_r == SBT_D_LOAD) && cur_r.write;

  // data tenure
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dstate_r <= SBT_D_IDLE;
    end else if (clk_en) begin
      unique case (dstate_r)
        SBT_D_IDLE: begin
          if (data_pending_r) begin
            dstate_r <= SBT_D_LOAD;
          end
        end
        SBT_D_LOAD: begin
          // reads wait for a drained fifo so a whole burst always fits
          if (cur_r.write ? wd_valid : (!rdq.out_valid && rdq.in_ready)) begin
            dstate_r <= SBT_D_REQ;
          end
        end
        SBT_D_REQ: begin
          if (bus_tick && !data_grant_n) begin
            dstate_r <= SBT_D_BEAT;
          end
        end
        SBT_D_BEAT: begin
          if (beat_ok && last_beat) begin
            dstate_r <= SBT_D_IDLE;
          end else if (beat_ok && cur_r.write) begin
            dstate_r <= SBT_D_LOAD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      beat_r <= '0;
    end else if (clk_en) begin
      if (dstate_r == SBT_D_IDLE) begin
        beat_r <= '0;
      end else if (beat_ok) begin
        beat_r <= beat_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out <= '0;
    end else if (wd_ready && wd_valid) begin
      data_out <= wd_data;
    end
  end

  // data pins; a retried beat keeps request and data unchanged
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_req_n <= 1'b1;
      data_oe <= 1'b0;
    end else if (bus_tick) begin
      data_req_n <= !((dstate_r == SBT_D_REQ) && data_grant_n);
      if ((dstate_r == SBT_D_REQ) && !data_grant_n) begin
        data_oe <= cur_r.write;
      end else if (beat_ok) begin
        data_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_pulse <= 1'b0;
    end else if (clk_en) begin
      done_pulse <= beat_ok && last_beat;
    end
  end

  // read beats go straight into the fifo; retried beats are dropped
  assign rdq.in_valid = beat_ok && !cur_r.write;
  assign rdq.in_data = data_in;
  assign rdq.out_ready = rd_ready;
  assign rd_valid = rdq.out_valid;
  assign rd_data = rdq.out_data;
endmodule

// ===== verification/sbt_bus_master_asserts.sv
// concurrent checks on the bus master's pins
`timescale 1ns/1ns
module sbt_bus_master_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // user side
  input wire logic req_ready,
  input wire logic done_pulse,
  input wire logic rd_valid,
  // address tenure
  input wire logic addr_req_n,
  input wire logic addr_grant_n,
  input wire logic transfer_begin_n,
  input wire logic [31:0] addr_out,
  input wire logic addr_oe,
  input wire logic [4:0] transfer_type_code,
  input wire logic [2:0] tsize_code,
  input wire logic burst_n,
  input wire logic address_retry_n,
  // data tenure
  input wire logic data_req_n,
  input wire logic data_grant_n,
  input wire logic data_oe,
  input wire logic data_ack_n,
  input wire logic data_retry_n,
  // clocking
  input wire logic [31:0] implementation_config_reg_one
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_begin_after_grant: assert property ($fell(transfer_begin_n) |-> !$past(addr_grant_n) && addr_req_n)
    else $error("transfer begin without address grant");
  a_begin_one_clock: assert property ($fell(transfer_begin_n) |-> (!transfer_begin_n)[*8] ##1 transfer_begin_n)
    else $error("transfer begin not one bus clock");
  a_attr_hold: assert property (addr_oe && $past(addr_oe) |-> $stable(addr_out) && $stable(transfer_type_code)
    && $stable(tsize_code) && $stable(burst_n)) else $error("address attributes moved");
  a_type_code: assert property (addr_oe |-> transfer_type_code inside {5'h0A, 5'h02})
    else $error("bad transfer type code");
  a_burst_size: assert property (addr_oe && !burst_n |-> tsize_code == 3'h2)
    else $error("burst with wrong size code");
  a_data_grant: assert property ($rose(data_oe) |-> !$past(data_grant_n))
    else $error("data driven without data grant");
  a_done_acked: assert property (done_pulse |-> !$past(data_ack_n) && $past(data_retry_n) && !$past(done_pulse))
    else $error("done without clean final ack");
  a_retry_no_push: assert property ($rose(rd_valid) |-> !$past(data_ack_n) && $past(data_retry_n))
    else $error("read word pushed without clean ack");
  a_addr_reissue: assert property (addr_oe && !address_retry_n |-> ##[0:24] !addr_req_n)
    else $error("no address rerequest after retry");
  a_ratio_field: assert property ($past(req_ready) |-> implementation_config_reg_one[27:0] == 28'h0
    && $stable(implementation_config_reg_one)) else $error("ratio register moved");
  a_ready_idle: assert property (req_ready |-> addr_req_n && data_req_n && !addr_oe && !data_oe)
    else $error("ready while a tenure is busy");
endmodule

bind sbt_bus_master sbt_bus_master_asserts chk (.core_clk, .reset, .req_ready, .done_pulse, .rd_valid,
  .addr_req_n, .addr_grant_n, .transfer_begin_n, .addr_out, .addr_oe, .transfer_type_code, .tsize_code,
  .burst_n, .address_retry_n, .data_req_n, .data_grant_n, .data_oe, .data_ack_n, .data_retry_n,
  .implementation_config_reg_one);

// ===== verification/sbt_far_model.sv
// arbiter and memory on the far side, clocked by the bus clock
`timescale 1ns/1ns
module sbt_far_model (
  // bus clock and reset
  input wire logic bus_clock_in,
  input wire logic reset,
  // retries wanted so far, from the bench
  input wire logic [3:0] a_goal,
  input wire logic [3:0] d_goal,
  // address tenure
  input wire logic addr_req_n,
  input wire logic transfer_begin_n,
  input wire logic addr_oe,
  input wire logic [31:0] addr_out,
  input wire logic burst_n,
  output logic addr_grant_n,
  output logic addr_ack_n,
  output logic address_retry_n,
  // data tenure
  input wire logic data_req_n,
  input wire logic data_oe,
  input wire logic [63:0] data_out,
  output logic data_grant_n,
  output logic data_ack_n,
  output logic data_retry_n,
  output logic [63:0] data_in
);
  logic [3:0] a_used, d_used;
  logic [1:0] beat;
  logic [31:0] lat_addr;
  logic dbusy;
  logic lat_burst;
  logic [63:0] wr_mem [0:3];
  always @(posedge bus_clock_in or posedge reset) begin
    if (reset) begin
      {addr_grant_n, addr_ack_n, address_retry_n, data_grant_n, data_ack_n, data_retry_n} <= 6'h3F;
      {a_used, d_used, beat, dbusy, lat_addr, lat_burst} <= '0;
      data_in <= 64'h0;
    end else begin
      addr_grant_n <= addr_req_n;
      data_grant_n <= data_req_n;
      {addr_ack_n, address_retry_n, data_ack_n, data_retry_n} <= 4'hF;
      // released data lines show the inverse, never a stale match
      data_in <= ~data_in;
      if (!transfer_begin_n) begin
        lat_addr <= addr_out;
        lat_burst <= !burst_n;
        beat <= 2'h0;
      end
      if (addr_oe && transfer_begin_n && addr_ack_n && address_retry_n) begin
        if (a_used != a_goal) begin
          address_retry_n <= 1'b0;
          a_used <= a_used + 4'h1;
        end else begin
          addr_ack_n <= 1'b0;
        end
      end
      if ((dbusy || (!data_grant_n && data_req_n)) && data_ack_n && data_retry_n) begin
        if (d_used != d_goal) begin
          data_retry_n <= 1'b0;
          d_used <= d_used + 4'h1;
          dbusy <= 1'b1;
        end else begin
          data_ack_n <= 1'b0;
          // read bursts stream under one grant; write beats re-arbitrate
          dbusy <= lat_burst && !data_oe && (beat != 2'h3);
          data_in <= {lat_addr, 24'h0, 6'h30, beat};
          beat <= beat + 2'h1;
          if (data_oe) wr_mem[beat] <= data_out;
        end
      end
    end
  end
endmodule

// ===== verification/sbt_bus_master_tb.sv
// self-checking bench for the bus master
`timescale 1ns/1ns
module sbt_bus_master_tb;
  import sbt_pkg::*;
  logic core_clk = 0, reset = 1, req_valid = 0, wd_valid = 0, rd_ready = 0, bus_clock_in = 0;
  sbt_req_t req_info = '0;
  logic [63:0] wd_data = 64'h0;
  logic [63:0] wq [0:3];
  logic [3:0] a_goal = 4'h0, d_goal = 4'h0, bdiv = 4'h0, ratio_pins = 4'h6;
  logic [10:0] at;
  int num_errors = 0, samples_checked = 0;
  logic req_ready, done_pulse, wd_ready, rd_valid, addr_req_n, addr_grant_n, transfer_begin_n, addr_oe;
  logic burst_n, write_thru_n, cache_inh_n, addr_ack_n, address_retry_n, data_req_n, data_grant_n;
  logic data_oe, data_ack_n, data_retry_n, clock_lock;
  logic [63:0] rd_data, data_in, data_out;
  logic [31:0] addr_out, implementation_config_reg_one;
  logic [4:0] transfer_type_code;
  logic [2:0] tsize_code;
  sbt_bus_master DUT (.core_clk, .reset, .clk_en(1'b1), .req_valid, .req_ready, .req_info, .done_pulse,
    .wd_valid, .wd_ready, .wd_data, .rd_valid, .rd_ready, .rd_data, .addr_req_n, .addr_grant_n,
    .transfer_begin_n, .addr_out, .addr_oe, .transfer_type_code, .tsize_code, .burst_n, .write_thru_n,
    .cache_inh_n, .addr_ack_n, .address_retry_n, .data_req_n, .data_grant_n, .data_in, .data_out, .data_oe,
    .data_ack_n, .data_retry_n, .bus_clock_in, .clk_ratio_cfg(ratio_pins), .implementation_config_reg_one,
    .clock_lock);
  sbt_far_model far (.bus_clock_in, .reset, .a_goal, .d_goal, .addr_req_n, .transfer_begin_n, .addr_oe,
    .addr_out, .burst_n, .addr_grant_n, .addr_ack_n, .address_retry_n, .data_req_n, .data_oe, .data_out,
    .data_grant_n, .data_ack_n, .data_retry_n, .data_in);
  initial forever #5 core_clk = ~core_clk;
  // bus clock is core divided by eight, steady halves
  always @(negedge core_clk) begin
    bdiv <= bdiv + 4'h1;
    bus_clock_in <= bdiv[2];
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic timeout;
    num_errors++;
    $display("BAD wait bound ran out");
    print_verdict();
  endtask
  task automatic run_req(input sbt_req_t r, input int nw);
    int n;
    int k;
    logic tk, wk, fin;
    k = 0;
    fin = 1'b0;
    @(negedge core_clk);
    req_info = r;
    req_valid = 1'b1;
    wd_valid = (nw > 0);
    wd_data = wq[0];
    for (n = 0; n < 3000 && !fin; n++) begin
      @(posedge core_clk);
      tk = req_valid & req_ready;
      wk = wd_valid & wd_ready;
      fin = (done_pulse === 1'b1);
      if (!transfer_begin_n) at = {transfer_type_code, tsize_code, burst_n, write_thru_n, cache_inh_n};
      @(negedge core_clk);
      if (tk) req_valid = 1'b0;
      if (wk) k++;
      wd_valid = (k < nw);
      wd_data = wq[k % 4];
    end
    if (!fin) timeout();
  endtask
  task automatic drain(input logic [31:0] a, input int nb);
    int i;
    for (i = 0; i < nb; i++) begin
      @(negedge core_clk);
      check("rd_valid", 64'h1, rd_valid);
      check("rd_data", {a, 32'h0000_00C0 | i}, rd_data);
      rd_ready = 1'b1;
      @(negedge core_clk);
      rd_ready = 1'b0;
    end
    @(negedge core_clk);
    check("rd_empty", 64'h0, rd_valid);
  endtask
  task automatic t_start(input logic [3:0] rp);
    int n;
    reset = 1'b1;
    ratio_pins = rp;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge core_clk);
    if (n == 100) timeout();
    check("ratio_reg", {32'h0, rp, 28'h0}, implementation_config_reg_one);
    // pins moving after the capture must not reach the register
    ratio_pins = ~rp;
    repeat (200) @(negedge core_clk);
    check("ratio_held", {32'h0, rp, 28'h0}, implementation_config_reg_one);
    check("clock_lock", 64'h1, clock_lock);
    $display("test start done");
  endtask
  task automatic t_read_single;
    run_req('{addr: 32'h1000_0040, write: 1'b0, burst: 1'b0, size: 4'h8, wt: 1'b0, ci: 1'b1}, 0);
    check("rd1_attr", {5'h0A, 3'h0, 3'b110}, at);
    drain(32'h1000_0040, 1);
    $display("test read single done");
  endtask
  task automatic t_read_burst;
    a_goal++;
    d_goal++;
    run_req('{addr: 32'h2000_0020, write: 1'b0, burst: 1'b1, size: 4'h2, wt: 1'b0, ci: 1'b0}, 0);
    check("rd4_attr", {5'h0A, 3'h2, 3'b011}, at);
    drain(32'h2000_0020, 4);
    $display("test read burst done");
  endtask
  task automatic t_write_burst;
    int i;
    for (i = 0; i < 4; i++) wq[i] = {32'h5A00_0000 + i, 32'hFFFF_0F00 - i};
    d_goal++;
    run_req('{addr: 32'h3000_0000, write: 1'b1, burst: 1'b1, size: 4'h2, wt: 1'b1, ci: 1'b0}, 4);
    check("wr4_attr", {5'h02, 3'h2, 3'b001}, at);
    for (i = 0; i < 4; i++) check("wr_mem", wq[i], far.wr_mem[i]);
    $display("test write burst done");
  endtask
  initial begin
    for (int i = 0; i < 4; i++) wq[i] = 64'h0;
    t_start(4'h6);
    t_read_single();
    t_read_burst();
    t_write_burst();
    t_start(4'h9);
    t_read_single();
    print_verdict();
  end
endmodule
